/* File: logic/fpc_special_unit.sv */
`include "fpc_defs.svh"

// Behaviour
// - In-range exponent is normal, hidden bit one
// - Lowest exponent, nonzero fraction is denormal
// - Lowest exponent, zero fraction is signed zero
// - Top exponent, zero fraction is signed infinity
// - New encoding: fraction msb zero signals
// - Legacy encoding: fraction msb one signals
// - Biases 127 and 1023, field widths
// - Division by zero gives signed infinity
// - Infinities order outside all finite values
// - Meaningful infinity arithmetic is exact, propagates
// - Meaningless infinity arithmetic is invalid
// - Signaling NaN operand raises invalid, except in moves
// - Arithmetic never delivers a signaling NaN
// - Moves copy anything, raise nothing
// - Quiet NaN in gives quiet NaN out
// - Quiet NaN priority first, second, third source
// - Signaling compares treat quiet NaN like signaling
// - Created single quiet NaN per encoding
// - Created double quiet NaN per encoding
// - NaN or infinity to integer gives max
// - Only signed word and longword integers
module fpc_special_unit (
   input  wire logic              i_clk,
   input  wire logic              i_rstn,
   input  wire logic              i_valid,
   input  wire fpc_pkg::fpc_req_t i_req,
   input  wire logic              i_nan_encoding_select,
   output logic                   o_valid,
   output fpc_pkg::fpc_res_t      o_result,
   output fpc_pkg::fpc_class_t    o_class_first,
   output fpc_pkg::fpc_class_t    o_class_second,
   output fpc_pkg::fpc_class_t    o_class_third
);

   // -------------------------------------------------------------------------
   // Decoding functions
   // -------------------------------------------------------------------------

   // Class, sign and unbiased exponent of one operand
   function automatic fpc_pkg::fpc_class_t classify(input logic [63:0]      v,
                                                    input fpc_pkg::fpc_fmt_t fmt,
                                                    input logic             nan_sel);
      logic [10:0]         e;
      logic [51:0]         f;
      logic                msb;
      logic                e_top;
      logic                sgn;
      logic [11:0]         bias;
      fpc_pkg::fpc_class_t c;
      if (fmt == fpc_pkg::fmt_double) begin
         e     = v[`FPC_D_EXP_HI:`FPC_D_EXP_LO];
         f     = v[`FPC_D_FRAC_MSB:0];
         msb   = v[`FPC_D_FRAC_MSB];
         sgn   = v[`FPC_D_SIGN];
         bias  = `FPC_BIAS_D;
      end else begin
         e     = {3'h0, v[`FPC_S_EXP_HI:`FPC_S_EXP_LO]};
         f     = {29'h0, v[`FPC_S_FRAC_MSB:0]};
         msb   = v[`FPC_S_FRAC_MSB];
         sgn   = v[`FPC_S_SIGN];
         bias  = `FPC_BIAS_S;
      end
      e_top    = (fmt == fpc_pkg::fmt_double) ? (&e) : (&e[7:0]);
      c.cls    = '0;
      c.sign   = sgn;
      if (e_top) begin
         if (f == 52'h0)
            c.cls[`FPC_CLS_INF] = 1'b1;
         else if (msb != nan_sel)
            c.cls[`FPC_CLS_SNAN] = 1'b1;
         else
            c.cls[`FPC_CLS_QNAN] = 1'b1;
      end else if (e == 11'h000) begin
         if (f == 52'h0)
            c.cls[`FPC_CLS_ZERO] = 1'b1;
         else
            c.cls[`FPC_CLS_DENORM] = 1'b1;
      end else begin
         c.cls[`FPC_CLS_NORM] = 1'b1;
      end
      // Denormals read as E_min-1: hidden bit zero, field zero minus bias
      c.hidden  = (e != 11'h000) & ~e_top;
      c.exp_unb = {1'h0, e} - bias;
      return c;
   endfunction

   function automatic logic is_nan(input fpc_pkg::fpc_class_t c);
      return c.cls[`FPC_CLS_SNAN] | c.cls[`FPC_CLS_QNAN];
   endfunction

   // Single values live in the low word, upper word forced to zero
   function automatic logic [63:0] fmt_value(input logic [63:0]       v,
                                             input fpc_pkg::fpc_fmt_t fmt);
      return (fmt == fpc_pkg::fmt_double) ? v : {`FPC_UPPER_PAD, v[31:0]};
   endfunction

   // Magnitude without the sign, for ordering
   function automatic logic [62:0] magnitude(input logic [63:0]       v,
                                             input fpc_pkg::fpc_fmt_t fmt);
      return (fmt == fpc_pkg::fmt_double) ? v[62:0] : {32'h0, v[30:0]};
   endfunction

   function automatic logic [63:0] make_inf(input fpc_pkg::fpc_fmt_t fmt,
                                            input logic              sgn);
      if (fmt == fpc_pkg::fmt_double)
         return {sgn, 63'h0} | `FPC_INF_D;
      return {`FPC_UPPER_PAD, {sgn, 31'h0} | `FPC_INF_S};
   endfunction

   function automatic logic [63:0] new_qnan(input fpc_pkg::fpc_fmt_t fmt,
                                            input logic              nan_sel);
      if (fmt == fpc_pkg::fmt_double)
         return nan_sel ? `FPC_QNAN_D_2008 : `FPC_QNAN_D_LEGACY;
      return {`FPC_UPPER_PAD, nan_sel ? `FPC_QNAN_S_2008 : `FPC_QNAN_S_LEGACY};
   endfunction

   // -------------------------------------------------------------------------
   // Operand classification
   // -------------------------------------------------------------------------
   fpc_pkg::fpc_class_t c1;
   fpc_pkg::fpc_class_t c2;
   fpc_pkg::fpc_class_t c3;
   logic [63:0]         v1;
   logic [63:0]         v2;
   logic [63:0]         v3;

   // Purely combinational, so the pipeline can steer on classes this cycle
   assign v1 = fmt_value(i_req.first_source_operand, i_req.fmt);
   assign v2 = fmt_value(i_req.second_source_operand, i_req.fmt);
   assign v3 = fmt_value(i_req.third_source_operand, i_req.fmt);
   assign c1 = classify(v1, i_req.fmt, i_nan_encoding_select);
   assign c2 = classify(v2, i_req.fmt, i_nan_encoding_select);
   assign c3 = classify(v3, i_req.fmt, i_nan_encoding_select);
   assign o_class_first  = c1;
   assign o_class_second = c2;
   assign o_class_third  = c3;

   // -------------------------------------------------------------------------
   // Operand usage and special-case terms
   // -------------------------------------------------------------------------
   logic is_arith;
   logic use2;
   logic use3;
   logic any_snan;
   logic any_qnan;
   logic [63:0] qnan_pick;
   logic s2eff;
   logic psign;
   logic prod_inv;
   logic prod_inf;
   logic inf_invalid;

   assign is_arith = i_req.op inside {fpc_pkg::op_add, fpc_pkg::op_sub, fpc_pkg::op_mul,
                                      fpc_pkg::op_div, fpc_pkg::op_sqrt, fpc_pkg::op_madd};
   assign use2 = is_arith && i_req.op != fpc_pkg::op_sqrt || i_req.op == fpc_pkg::op_cmp;
   assign use3 = i_req.op == fpc_pkg::op_madd;

   // Which operands carry NaNs, only among those the operation reads
   assign any_snan = c1.cls[`FPC_CLS_SNAN] | (use2 & c2.cls[`FPC_CLS_SNAN])
                   | (use3 & c3.cls[`FPC_CLS_SNAN]);
   assign any_qnan = c1.cls[`FPC_CLS_QNAN] | (use2 & c2.cls[`FPC_CLS_QNAN])
                   | (use3 & c3.cls[`FPC_CLS_QNAN]);

   // First quiet NaN by source order; a signaling one is never picked
   always_comb begin
      if (c1.cls[`FPC_CLS_QNAN])
         qnan_pick = v1;
      else if (use2 && c2.cls[`FPC_CLS_QNAN])
         qnan_pick = v2;
      else
         qnan_pick = v3;
   end

   // Sign terms: subtraction flips the second operand
   assign s2eff    = c2.sign ^ (i_req.op == fpc_pkg::op_sub);
   assign psign    = c1.sign ^ c2.sign;
   assign prod_inv = (c1.cls[`FPC_CLS_INF] & c2.cls[`FPC_CLS_ZERO])
                   | (c1.cls[`FPC_CLS_ZERO] & c2.cls[`FPC_CLS_INF]);
   assign prod_inf = c1.cls[`FPC_CLS_INF] | c2.cls[`FPC_CLS_INF];

   // Invalid cases with no real limit, infinite operands plus 0/0 and negative roots
   always_comb begin
      unique case (i_req.op)
         fpc_pkg::op_add, fpc_pkg::op_sub:
            inf_invalid = c1.cls[`FPC_CLS_INF] & c2.cls[`FPC_CLS_INF]
                        & (c1.sign != s2eff);
         fpc_pkg::op_mul:
            inf_invalid = prod_inv;
         fpc_pkg::op_div:
            inf_invalid = (c1.cls[`FPC_CLS_INF] & c2.cls[`FPC_CLS_INF])
                        | (c1.cls[`FPC_CLS_ZERO] & c2.cls[`FPC_CLS_ZERO]);
         fpc_pkg::op_sqrt:
            inf_invalid = c1.sign & ~c1.cls[`FPC_CLS_ZERO];
         fpc_pkg::op_madd:
            inf_invalid = prod_inv | (prod_inf & c3.cls[`FPC_CLS_INF]
                        & (psign != c3.sign));
         default:
            inf_invalid = 1'b0;
      endcase
   end

   // -------------------------------------------------------------------------
   // Result selection
   // -------------------------------------------------------------------------
   fpc_pkg::fpc_res_t next_res;
   logic [62:0]       m1;
   logic [62:0]       m2;

   assign m1 = magnitude(v1, i_req.fmt);
   assign m2 = magnitude(v2, i_req.fmt);

   // Special cases decided here; special low hands off to the datapath
   always_comb begin
      next_res = '0;
      unique case (i_req.op)
         fpc_pkg::op_move: begin
            next_res.special = 1'b1;
            next_res.value   = v1;
         end
         fpc_pkg::op_move_cond: begin
            // Second source carries the destination's prior contents
            next_res.special = 1'b1;
            next_res.value   = i_req.cond ? v1 : v2;
         end
         fpc_pkg::op_cmp: begin
            next_res.special   = 1'b1;
            next_res.cmp_unord = is_nan(c1) | is_nan(c2);
            // Signaling compares trap on quiet NaNs too
            next_res.invalid   = any_snan | (any_qnan & i_req.cmp_signaling);
            if (!next_res.cmp_unord) begin
               if (c1.cls[`FPC_CLS_ZERO] && c2.cls[`FPC_CLS_ZERO])
                  next_res.cmp_eq = 1'b1;
               else if (c1.sign != c2.sign)
                  next_res.cmp_lt = c1.sign;
               else if (m1 == m2)
                  next_res.cmp_eq = 1'b1;
               else
                  next_res.cmp_lt = c1.sign ? (m1 > m2) : (m1 < m2);
            end
         end
         fpc_pkg::op_cvt_word, fpc_pkg::op_cvt_long: begin
            // Encoding select has no say here; only signed targets exist
            if (is_nan(c1) || c1.cls[`FPC_CLS_INF]) begin
               next_res.special = 1'b1;
               next_res.invalid = 1'b1;
               next_res.value   = (i_req.op == fpc_pkg::op_cvt_long) ? `FPC_INT_MAX_L
                                : {`FPC_UPPER_PAD, `FPC_INT_MAX_W};
            end
         end
         default: begin
            next_res.special = 1'b1;
            if (any_snan) begin
               next_res.invalid = 1'b1;
               next_res.value   = any_qnan ? qnan_pick
                                : new_qnan(i_req.fmt, i_nan_encoding_select);
            end else if (any_qnan) begin
               next_res.value = qnan_pick;
            end else if (inf_invalid) begin
               next_res.invalid = 1'b1;
               next_res.value   = new_qnan(i_req.fmt, i_nan_encoding_select);
            end else if (i_req.op == fpc_pkg::op_div && c2.cls[`FPC_CLS_ZERO]
                         && !c1.cls[`FPC_CLS_INF]) begin
               next_res.div_zero = 1'b1;
               next_res.value    = make_inf(i_req.fmt, psign);
            end else if (i_req.op inside {fpc_pkg::op_add, fpc_pkg::op_sub}
                         && prod_inf) begin
               next_res.value = make_inf(i_req.fmt,
                                         c1.cls[`FPC_CLS_INF] ? c1.sign : s2eff);
            end else if (i_req.op == fpc_pkg::op_mul && prod_inf) begin
               next_res.value = make_inf(i_req.fmt, psign);
            end else if (i_req.op == fpc_pkg::op_div && c1.cls[`FPC_CLS_INF]) begin
               next_res.value = make_inf(i_req.fmt, psign);
            end else if (i_req.op == fpc_pkg::op_sqrt && c1.cls[`FPC_CLS_INF]) begin
               next_res.value = v1;
            end else if (use3 && (prod_inf || c3.cls[`FPC_CLS_INF])) begin
               next_res.value = make_inf(i_req.fmt, prod_inf ? psign : c3.sign);
            end else begin
               next_res.special = 1'b0;
            end
         end
      endcase
   end

   // -------------------------------------------------------------------------
   // Output stage
   // -------------------------------------------------------------------------

   // One-cycle answer strobe
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn)
         o_valid <= 1'b0;
      else
         o_valid <= i_valid;
   end

   // Result held until the next request, so late readers still see it
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn)
         o_result <= '0;
      else if (i_valid)
         o_result <= next_res;
   end

   // Context kept beside the result for checking the delivered value
   logic                r_fp_out;
   fpc_pkg::fpc_fmt_t   r_fmt;
   logic                r_sel;
   fpc_pkg::fpc_class_t res_cls;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         r_fp_out <= 1'b0;
         r_fmt    <= fpc_pkg::fmt_single;
         r_sel    <= 1'b0;
      end else if (i_valid) begin
         r_fp_out <= is_arith;
         r_fmt    <= i_req.fmt;
         r_sel    <= i_nan_encoding_select;
      end
   end

   assign res_cls = classify(o_result.value, r_fmt, r_sel);

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   a_move_no_flags:
   assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_valid && i_req.op == fpc_pkg::op_move
      |=> o_valid && !o_result.invalid && o_result.value == $past(v1))
   else $error("Move changed its operand or raised invalid");

   a_snan_raises_invalid:
   assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_valid && is_arith && c1.cls[`FPC_CLS_SNAN] |=> o_result.invalid)
   else $error("Signaling NaN operand did not raise invalid");

   a_no_snan_result:
   assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_valid && o_result.special && r_fp_out |-> !res_cls.cls[`FPC_CLS_SNAN])
   else $error("Signaling NaN delivered as a result");

   a_qnan_first_source:
   assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_valid && is_arith && !any_snan && c1.cls[`FPC_CLS_QNAN]
      |=> !o_result.invalid && o_result.value == $past(v1))
   else $error("Quiet NaN of first source not propagated");

   a_cvt_int_max:
   assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_valid && i_req.op == fpc_pkg::op_cvt_word && c1.cls[`FPC_CLS_INF]
      |=> o_result.invalid && o_result.value == {`FPC_UPPER_PAD, `FPC_INT_MAX_W})
   else $error("Infinity to word did not give largest integer");

   a_div_zero_inf:
   assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_valid && i_req.op == fpc_pkg::op_div && c1.cls[`FPC_CLS_NORM]
      && c2.cls[`FPC_CLS_ZERO]
      |=> o_result.div_zero && res_cls.cls[`FPC_CLS_INF]
      && res_cls.sign == $past(psign))
   else $error("Division by zero did not give signed infinity");

   a_default_qnan:
   assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_valid && i_req.op == fpc_pkg::op_add && i_req.fmt == fpc_pkg::fmt_single
      && c1.cls[`FPC_CLS_INF] && c2.cls[`FPC_CLS_INF] && c1.sign != c2.sign
      |=> o_result.invalid && o_result.value[31:0] == ($past(i_nan_encoding_select)
          ? `FPC_QNAN_S_2008 : `FPC_QNAN_S_LEGACY))
   else $error("Wrong quiet NaN created for invalid addition");

   a_cmp_inf_order:
   assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_valid && i_req.op == fpc_pkg::op_cmp && c1.cls[`FPC_CLS_INF] && c1.sign
      && (c2.cls[`FPC_CLS_NORM] || c2.cls[`FPC_CLS_DENORM] || c2.cls[`FPC_CLS_ZERO])
      |=> o_result.cmp_lt && !o_result.cmp_eq && !o_result.cmp_unord)
   else $error("Minus infinity did not compare below a finite value");

   a_class_onehot:
   assert property (@(posedge i_clk) disable iff (!i_rstn)
      $onehot(c1.cls) && $onehot(c2.cls) && $onehot(c3.cls))
   else $error("Operand class vector is not one-hot");

endmodule // fpc_special_unit

/* File: logic/fpc_defs.svh */
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

// ----------------------------------------------------------------------------
// Field positions of the two floating-point formats
// ----------------------------------------------------------------------------
`define FPC_S_SIGN         31
`define FPC_S_EXP_HI       30
`define FPC_S_EXP_LO       23
`define FPC_S_FRAC_MSB     22
`define FPC_D_SIGN         63
`define FPC_D_EXP_HI       62
`define FPC_D_EXP_LO       52
`define FPC_D_FRAC_MSB     51

// ----------------------------------------------------------------------------
// Exponent biases
// ----------------------------------------------------------------------------
`define FPC_BIAS_S         12'h07F
`define FPC_BIAS_D         12'h3FF

// ----------------------------------------------------------------------------
// One-hot class vector layout
// ----------------------------------------------------------------------------
`define FPC_CLS_W          6
`define FPC_CLS_ZERO       0
`define FPC_CLS_DENORM     1
`define FPC_CLS_NORM       2
`define FPC_CLS_INF        3
`define FPC_CLS_SNAN       4
`define FPC_CLS_QNAN       5

// ----------------------------------------------------------------------------
// Created values
// ----------------------------------------------------------------------------
`define FPC_QNAN_S_LEGACY  32'h7FBF_FFFF
`define FPC_QNAN_S_2008    32'h7FFF_FFFF
`define FPC_QNAN_D_LEGACY  64'h7FF7_FFFF_FFFF_FFFF
`define FPC_QNAN_D_2008    64'h7FFF_FFFF_FFFF_FFFF
`define FPC_INT_MAX_W      32'h7FFF_FFFF
`define FPC_INT_MAX_L      64'h7FFF_FFFF_FFFF_FFFF
`define FPC_INF_S          32'h7F80_0000
`define FPC_INF_D          64'h7FF0_0000_0000_0000
`define FPC_UPPER_PAD      32'h0000_0000

`endif

/* File: logic/fpc_pkg.sv */
`include "fpc_defs.svh"

package fpc_pkg;

   // -------------------------------------------------------------------------
   // Operations and formats
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      op_add       = 4'h0,
      op_sub       = 4'h1,
      op_mul       = 4'h2,
      op_div       = 4'h3,
      op_sqrt      = 4'h4,
      op_madd      = 4'h5,
      op_cmp       = 4'h6,
      op_cvt_word  = 4'h7,
      op_cvt_long  = 4'h8,
      op_move      = 4'h9,
      op_move_cond = 4'hA
   } fpc_op_t;

   typedef enum logic {
      fmt_single = 1'h0,
      fmt_double = 1'h1
   } fpc_fmt_t;

   // -------------------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic                    sign;
      logic [`FPC_CLS_W-1:0]   cls;
      logic                    hidden;
      logic [11:0]             exp_unb;
   } fpc_class_t;

   typedef struct packed {
      fpc_op_t     op;
      fpc_fmt_t    fmt;
      logic        cond;
      logic        cmp_signaling;
      logic [63:0] first_source_operand;
      logic [63:0] second_source_operand;
      logic [63:0] third_source_operand;
   } fpc_req_t;

   typedef struct packed {
      logic        special;
      logic [63:0] value;
      logic        invalid;
      logic        div_zero;
      logic        cmp_lt;
      logic        cmp_eq;
      logic        cmp_unord;
   } fpc_res_t;

endpackage : fpc_pkg

/* File: tb/fpc_pipe_model.sv */
// ----------------------------------------------------------------------------
// Issuing side of the integer pipeline
// ----------------------------------------------------------------------------
module fpc_pipe_model (
   input  wire logic          i_clk,
   output logic               o_valid,
   output fpc_pkg::fpc_req_t  o_req
);
   timeunit 1ns;
   timeprecision 1ps;

   logic               cond_sel = 1'b1;  // Move condition, set by the bench

   // Quiet bus before the first request
   initial begin
      o_valid = 1'b0;
      o_req   = '0;
   end

   // Request and qualifiers stay put until the taking edge has passed
   task automatic drive(input fpc_pkg::fpc_op_t o, input fpc_pkg::fpc_fmt_t f,
                        input logic cs, input logic [63:0] a, b, c);
      o_valid = 1'b1;
      o_req   = '{o, f, cond_sel, cs, a, b, c};
   endtask

   // Released operands are inverted so a stale value never looks valid
   task automatic idle();
      o_valid                     = 1'b0;
      o_req.first_source_operand  = ~o_req.first_source_operand;
      o_req.second_source_operand = ~o_req.second_source_operand;
      o_req.third_source_operand  = ~o_req.third_source_operand;
   endtask
endmodule // fpc_pipe_model

/* File: tb/fpc_special_unit_tb.sv */
module fpc_special_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 i_clk, i_rstn, sel, pv, o_valid;
   fpc_pkg::fpc_req_t    req;
   fpc_pkg::fpc_res_t    res;
   fpc_pkg::fpc_class_t  c1, c2, c3;
   int                   num_errors = 0;
   int                   n_checks = 0;

   fpc_pipe_model PIPE (.i_clk(i_clk), .o_valid(pv), .o_req(req));
   fpc_special_unit DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(pv), .i_req(req),
      .i_nan_encoding_select(sel), .o_valid(o_valid), .o_result(res),
      .o_class_first(c1), .o_class_second(c2), .o_class_third(c3));

   // ----------------------------------------------------------------------------
   // Clock and helpers
   // ----------------------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Class read before the taking edge, since it is combinational
   task automatic cls(input logic [31:0] a, input logic s, input logic [5:0] k,
                      input logic he, input logic [12:0] hx);
      PIPE.drive(fpc_pkg::op_cmp, fpc_pkg::fmt_single, 1'b0, {32'h0, a}, {32'h0, a},
                 {32'h0, a});
      #1 chk({57'h0, c1.sign, c1.cls}, {57'h0, s, k});
      chk({52'h0, c2.cls, c3.cls}, {52'h0, k, k});
      if (he) chk({51'h0, c1.hidden, c1.exp_unb}, {51'h0, hx});
      @(negedge i_clk);
      PIPE.idle();
      @(negedge i_clk);
   endtask

   // Answer pulse starts at the taking edge, read at the next negedge; flags are inv,dz,lt,eq,unord
   task automatic op(input fpc_pkg::fpc_op_t o, input fpc_pkg::fpc_fmt_t f,
                     input logic cs, input logic [63:0] a, b, c, input logic cv,
                     input logic [63:0] v, input logic [4:0] fl);
      PIPE.drive(o, f, cs, a, b, c);
      @(negedge i_clk);
      PIPE.idle();
      chk({63'h0, o_valid}, 64'h1);
      if (cv) chk(res.value, v);
      chk({63'h0, res.special}, 64'h1);
      chk({59'h0, res.invalid, res.div_zero, res.cmp_lt, res.cmp_eq, res.cmp_unord},
          {59'h0, fl});
      @(negedge i_clk);
      chk({63'h0, o_valid}, 64'h0);
   endtask

   // ----------------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------------
   task automatic t_class();
      sel = 1'b1;
      cls(32'h8000_0000, 1'b1, 6'h01, 1'b0, 13'h0);
      cls(32'hFF80_0000, 1'b1, 6'h08, 1'b0, 13'h0);
      cls(32'h0080_0000, 1'b0, 6'h04, 1'b1, 13'h1F82);
      cls(32'h007F_FFFF, 1'b0, 6'h02, 1'b1, 13'h0F81);
      cls(32'h7FBF_FFFF, 1'b0, 6'h10, 1'b0, 13'h0);
      sel = 1'b0;
      cls(32'h7FFF_FFFF, 1'b0, 6'h10, 1'b0, 13'h0);
      cls(32'h7FBF_FFFF, 1'b0, 6'h20, 1'b0, 13'h0);
      $display("test class done");
   endtask

   task automatic t_inf();
      for (int s = 0; s < 2; s++) begin
         sel = s[0];
         op(fpc_pkg::op_add, fpc_pkg::fmt_single, 1'b0, 64'h7F80_0000, 64'hFF80_0000, 64'h0,
            1'b1, s ? 64'h7FFF_FFFF : 64'h7FBF_FFFF, 5'h10);
         op(fpc_pkg::op_add, fpc_pkg::fmt_double, 1'b0, 64'h7FF0_0000_0000_0000,
            64'hFFF0_0000_0000_0000, 64'h0, 1'b1,
            s ? 64'h7FFF_FFFF_FFFF_FFFF : 64'h7FF7_FFFF_FFFF_FFFF, 5'h10);
      end
      op(fpc_pkg::op_div, fpc_pkg::fmt_single, 1'b0, 64'hBF80_0000, 64'h0, 64'h0,
         1'b1, 64'hFF80_0000, 5'h08);
      op(fpc_pkg::op_add, fpc_pkg::fmt_single, 1'b0, 64'h7F80_0000, 64'h3F80_0000, 64'h0,
         1'b1, 64'h7F80_0000, 5'h00);
      op(fpc_pkg::op_cmp, fpc_pkg::fmt_single, 1'b0, 64'hFF80_0000, 64'h3F80_0000, 64'h0,
         1'b0, 64'h0, 5'h04);
      op(fpc_pkg::op_sub, fpc_pkg::fmt_single, 1'b0, 64'h7F80_0000, 64'h7F80_0000, 64'h0,
         1'b1, 64'h7FFF_FFFF, 5'h10);
      op(fpc_pkg::op_mul, fpc_pkg::fmt_single, 1'b0, 64'h0, 64'hFF80_0000, 64'h0,
         1'b1, 64'h7FFF_FFFF, 5'h10);
      op(fpc_pkg::op_mul, fpc_pkg::fmt_double, 1'b0, 64'hBFF0_0000_0000_0000,
         64'h7FF0_0000_0000_0000, 64'h0, 1'b1, 64'hFFF0_0000_0000_0000, 5'h00);
      op(fpc_pkg::op_sqrt, fpc_pkg::fmt_single, 1'b0, 64'h7F80_0000, 64'h0, 64'h0,
         1'b1, 64'h7F80_0000, 5'h00);
      op(fpc_pkg::op_sqrt, fpc_pkg::fmt_single, 1'b0, 64'hBF80_0000, 64'h0, 64'h0,
         1'b1, 64'h7FFF_FFFF, 5'h10);
      op(fpc_pkg::op_cmp, fpc_pkg::fmt_single, 1'b0, 64'h8000_0000, 64'h0, 64'h0,
         1'b0, 64'h0, 5'h02);
      op(fpc_pkg::op_cvt_word, fpc_pkg::fmt_single, 1'b0, 64'hFF80_0000, 64'h0, 64'h0,
         1'b1, 64'h7FFF_FFFF, 5'h10);
      $display("test infinity done");
   endtask

   task automatic t_nan();
      sel = 1'b1;
      op(fpc_pkg::op_add, fpc_pkg::fmt_single, 1'b0, 64'h7FBF_FFFF, 64'h3F80_0000, 64'h0,
         1'b1, 64'h7FFF_FFFF, 5'h10);
      op(fpc_pkg::op_madd, fpc_pkg::fmt_single, 1'b0, 64'h3F80_0000, 64'h7FC0_0001,
         64'h7FC0_0002, 1'b1, 64'h7FC0_0001, 5'h00);
      op(fpc_pkg::op_madd, fpc_pkg::fmt_single, 1'b0, 64'h7FC0_0003, 64'h7FC0_0001,
         64'h7FC0_0002, 1'b1, 64'h7FC0_0003, 5'h00);
      op(fpc_pkg::op_add, fpc_pkg::fmt_single, 1'b0, 64'h7FBF_FFFF, 64'h7FC0_0001, 64'h0,
         1'b1, 64'h7FC0_0001, 5'h10);
      op(fpc_pkg::op_move, fpc_pkg::fmt_single, 1'b0, 64'h7FBF_FFFF, 64'h0, 64'h0,
         1'b1, 64'h7FBF_FFFF, 5'h00);
      op(fpc_pkg::op_move_cond, fpc_pkg::fmt_single, 1'b0, 64'h7FBF_FFFF, 64'h1, 64'h0,
         1'b1, 64'h7FBF_FFFF, 5'h00);
      PIPE.cond_sel = 1'b0;
      op(fpc_pkg::op_move_cond, fpc_pkg::fmt_single, 1'b0, 64'h1, 64'h7FBF_FFFF, 64'h0,
         1'b1, 64'h7FBF_FFFF, 5'h00);
      PIPE.cond_sel = 1'b1;
      op(fpc_pkg::op_cmp, fpc_pkg::fmt_single, 1'b1, 64'h7FC0_0001, 64'h3F80_0000, 64'h0,
         1'b0, 64'h0, 5'h11);
      op(fpc_pkg::op_cvt_word, fpc_pkg::fmt_single, 1'b0, 64'h7FC0_0001, 64'h0, 64'h0,
         1'b1, 64'h7FFF_FFFF, 5'h10);
      op(fpc_pkg::op_cvt_long, fpc_pkg::fmt_double, 1'b0, 64'hFFF0_0000_0000_0000, 64'h0,
         64'h0, 1'b1, 64'h7FFF_FFFF_FFFF_FFFF, 5'h10);
      $display("test nan done");
   endtask

   // ----------------------------------------------------------------------------
   // Sequence, verdict and watchdog
   // ----------------------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      i_rstn = 1'b0;
      sel    = 1'b0;
      repeat (5) @(negedge i_clk);
      chk({63'h0, o_valid}, 64'h0);
      i_rstn = 1'b1;
      t_class();
      t_inf();
      t_nan();
      end_of_test();
   end

   // Whole run is under a hundred cycles; this leaves ample margin
   initial begin
      #20us;
      num_errors++;
      end_of_test();
   end
endmodule // fpc_special_unit_tb
